// >>> src/msd_decoder.sv
// memory site decoder top: cpu cycle decode, gating and axi4-lite registers
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module msd_decoder
   import msd_pkg::*;
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write
   input  wire logic [msd_pkg::REG_AW-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read
   input  wire logic [msd_pkg::REG_AW-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // processor local bus
   input  wire logic                  cpu_req,
   input  wire logic                  cpu_wr,
   input  wire logic [msd_pkg::CPU_AW-1:0] cpu_addr,
   output logic                       cpu_busy,
   output logic                       cpu_ready,
   output logic                       cpu_fault,
   // auxiliary control connector
   input  wire logic                  aux_mem_protect,
   // memory sites
   output logic [3:0]                 prog_cs,
   output logic [3:0]                 data_cs,
   output logic [3:0]                 addon_cs,
   output logic [msd_pkg::DEV_AW-1:0] dev_addr,
   output logic                       dev_oe,
   output logic                       dev_we
);
   // ***********************************************************
   // declarations
   // ***********************************************************
   logic [CFG_W-1:0]  cfg_r, cfg_nxt, live_r, live_nxt;
   logic [REG_AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0]        wstrb_r, wstrb_nxt;
   logic              aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic              awready_r, awready_nxt, wready_r, wready_nxt;
   logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt;
   logic              rvalid_r, rvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic              fault_st_r, fault_st_nxt;
   logic [CNT_W-1:0]  blk_cnt_r, blk_cnt_nxt;
   logic              do_write, wr_fault_clr, wr_cnt_clr;
   msd_cyc_e          cyc_r, cyc_nxt;
   logic [1:0]        grp_r, grp_nxt, last_grp_r, last_grp_nxt;
   logic [3:0]        pcs_r, pcs_nxt, dcs_r, dcs_nxt, acs_r, acs_nxt;
   logic [DEV_AW-1:0] daddr_r, daddr_nxt;
   logic              oe_r, oe_nxt, we_r, we_nxt;
   logic              rdy_r, rdy_nxt, flt_r, flt_nxt, busy_r, busy_nxt;
   logic              blocked;
   logic [2:0]        psz;
   logic [1:0]        dsz;
   logic [4:0]        pbits, dbits, abits;
   logic [20:0]       pbase, dbase, abase, dsize;
   logic              p_hit, d_hit, a_hit, wait_load, wait_done, ws_abort;
   logic [1:0]        p_site, d_site, a_site;
   logic [DEV_AW-1:0] p_ofs, d_ofs, a_ofs;
   logic [3:0]        site_dec;

   // ***********************************************************
   // memory map from the live configuration
   // ***********************************************************
   always_comb begin
      psz = live_r[CFG_PSZ_LSB +: 3];
      dsz = live_r[CFG_DSZ_LSB +: 2];
      unique case (psz)
         PSZ_16K:  pbits = BITS_64KB;
         PSZ_32K:  pbits = BITS_128KB;
         PSZ_64K:  pbits = BITS_256KB;
         PSZ_EE2K: pbits = live_r[CFG_EE8K] ? BITS_32KB : BITS_8KB;
         default:  pbits = BITS_32KB;
      endcase
      unique case (dsz)
         DSZ_8K:  dbits = BITS_32KB;
         DSZ_32K: dbits = BITS_128KB;
         default: dbits = BITS_8KB;
      endcase
      abits = (dbits > BITS_ADDON_MX) ? BITS_ADDON_MX : dbits;
      dsize = SPACE_TOP >> (BITS_256KB + SITE_SHIFT - dbits);
      pbase = SPACE_TOP - (SPACE_TOP >> (BITS_256KB + SITE_SHIFT - pbits));
      dbase = live_r[CFG_RELOC] ? pbase - dsize : SPACE_BOTTOM;
      abase = dbase + dsize;
   end

   // one window per site group, four sites each
   msd_range u_prog (
      .en     (1'b1),
      .base   (pbase),
      .bits   (pbits),
      .addr   (cpu_addr),
      .hit    (p_hit),
      .site   (p_site),
      .offset (p_ofs)
   );
   msd_range u_data (
      .en     (1'b1),
      .base   (dbase),
      .bits   (dbits),
      .addr   (cpu_addr),
      .hit    (d_hit),
      .site   (d_site),
      .offset (d_ofs)
   );
   msd_range u_addon (
      .en     (live_r[CFG_ADDON]),
      .base   (abase),
      .bits   (abits),
      .addr   (cpu_addr),
      .hit    (a_hit),
      .site   (a_site),
      .offset (a_ofs)
   );

   msd_wait u_wait (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (wait_load),
      .abort   (ws_abort),
      .waits   (live_r[CFG_WS_LSB +: 2]),
      .done    (wait_done)
   );

   // ***********************************************************
   // cpu cycle sequencing
   // ***********************************************************
   // the cpu local bus is the only requester of the sites
   always_comb begin
      cyc_nxt      = cyc_r;
      grp_nxt      = grp_r;
      last_grp_nxt = last_grp_r;
      pcs_nxt      = pcs_r;
      dcs_nxt      = dcs_r;
      acs_nxt      = acs_r;
      daddr_nxt    = daddr_r;
      oe_nxt       = oe_r;
      we_nxt       = we_r;
      rdy_nxt      = 1'b0;
      flt_nxt      = 1'b0;
      blocked      = 1'b0;
      wait_load    = 1'b0;
      ws_abort     = 1'b0;
      live_nxt     = live_r;
      site_dec     = 4'h0;
      unique case (cyc_r)
         CYC_IDLE: begin
            if (cpu_req) begin
               // program group wins, then data, then add-on
               if (p_hit) begin
                  grp_nxt   = GRP_PROG;
                  site_dec  = 4'h1 << p_site;
                  daddr_nxt = (psz == PSZ_EE2K) ? DEV_AW'(p_ofs[EE2K_OFS_W-1:0]) : p_ofs;
               end else if (d_hit) begin
                  grp_nxt   = GRP_DATA;
                  site_dec  = 4'h1 << d_site;
                  daddr_nxt = d_ofs;
               end else if (a_hit) begin
                  grp_nxt   = GRP_ADDON;
                  site_dec  = 4'h1 << a_site;
                  daddr_nxt = a_ofs;
               end else begin
                  grp_nxt   = GRP_NONE;
               end
               blocked      = aux_mem_protect && (grp_nxt == GRP_DATA || grp_nxt == GRP_ADDON);
               last_grp_nxt = grp_nxt;
               if (grp_nxt == GRP_NONE || blocked) begin
                  flt_nxt = 1'b1;
               end else begin
                  cyc_nxt   = CYC_ACCESS;
                  wait_load = 1'b1;
                  oe_nxt    = !cpu_wr;
                  we_nxt    = cpu_wr;
                  pcs_nxt   = (grp_nxt == GRP_PROG) ? site_dec : 4'h0;
                  dcs_nxt   = (grp_nxt == GRP_DATA) ? site_dec : 4'h0;
                  acs_nxt   = (grp_nxt == GRP_ADDON) ? site_dec : 4'h0;
               end
            end else begin
               live_nxt = cfg_r;
            end
         end
         CYC_ACCESS: begin
            blocked = aux_mem_protect && grp_r != GRP_PROG;
            if (blocked || wait_done) begin
               ws_abort = blocked;
               cyc_nxt  = CYC_IDLE;
               rdy_nxt  = !blocked;
               flt_nxt  = blocked;
               pcs_nxt  = 4'h0;
               dcs_nxt  = 4'h0;
               acs_nxt  = 4'h0;
               oe_nxt   = 1'b0;
               we_nxt   = 1'b0;
            end
         end
      endcase
      busy_nxt = cyc_nxt == CYC_ACCESS;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cyc_r      <= CYC_IDLE;
         grp_r      <= GRP_NONE;
         last_grp_r <= GRP_NONE;
         pcs_r      <= 4'h0;
         dcs_r      <= 4'h0;
         acs_r      <= 4'h0;
         daddr_r    <= '0;
         oe_r       <= 1'b0;
         we_r       <= 1'b0;
         rdy_r      <= 1'b0;
         flt_r      <= 1'b0;
         busy_r     <= 1'b0;
         live_r     <= CFG_RESET;
      end else begin
         cyc_r      <= cyc_nxt;
         grp_r      <= grp_nxt;
         last_grp_r <= last_grp_nxt;
         pcs_r      <= pcs_nxt;
         dcs_r      <= dcs_nxt;
         acs_r      <= acs_nxt;
         daddr_r    <= daddr_nxt;
         oe_r       <= oe_nxt;
         we_r       <= we_nxt;
         rdy_r      <= rdy_nxt;
         flt_r      <= flt_nxt;
         busy_r     <= busy_nxt;
         live_r     <= live_nxt;
      end
   end

   // ***********************************************************
   // axi4-lite register slave
   // ***********************************************************
   always_comb begin
      aw_have_nxt  = aw_have_r;
      w_have_nxt   = w_have_r;
      awaddr_nxt   = awaddr_r;
      wdata_nxt    = wdata_r;
      wstrb_nxt    = wstrb_r;
      bvalid_nxt   = bvalid_r && !s_axi_bready;
      bresp_nxt    = bresp_r;
      cfg_nxt      = cfg_r;
      wr_fault_clr = 1'b0;
      wr_cnt_clr   = 1'b0;
      if (s_axi_awvalid && awready_r) begin
         aw_have_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_have_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
         wstrb_nxt  = s_axi_wstrb;
      end
      do_write = aw_have_r && w_have_r && !bvalid_r;
      if (do_write) begin
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = RESP_OKAY;
         unique case (awaddr_r)
            REG_CFG: begin
               if (wstrb_r[0]) cfg_nxt[7:0] = wdata_r[7:0];
               if (wstrb_r[1]) cfg_nxt[CFG_W-1:8] = wdata_r[CFG_W-1:8];
            end
            REG_STATUS:  wr_fault_clr = wstrb_r[0] && wdata_r[ST_FAULT];
            REG_BLOCKED: wr_cnt_clr = |wstrb_r;
            default:     bresp_nxt = RESP_SLVERR;
         endcase
      end
      awready_nxt = !aw_have_nxt && !bvalid_nxt;
      wready_nxt  = !w_have_nxt && !bvalid_nxt;
      // sticky fault and blocked count: a new event beats a clear
      fault_st_nxt = flt_nxt || (fault_st_r && !wr_fault_clr);
      blk_cnt_nxt  = wr_cnt_clr ? '0 : blk_cnt_r;
      if (blocked && blk_cnt_nxt != {CNT_W{1'b1}}) blk_cnt_nxt = blk_cnt_nxt + 1'b1;
      // read channel
      rvalid_nxt = rvalid_r && !s_axi_rready;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         rdata_nxt  = 32'h0000_0000;
         unique case (s_axi_araddr)
            REG_CFG: rdata_nxt[CFG_W-1:0] = cfg_r;
            REG_STATUS: begin
               rdata_nxt[ST_BUSY]           = busy_r;
               rdata_nxt[ST_PROT]           = aux_mem_protect;
               rdata_nxt[ST_GRP_LSB +: 2]   = last_grp_r;
               rdata_nxt[ST_FAULT]          = fault_st_r;
            end
            REG_BLOCKED: rdata_nxt[CNT_W-1:0] = blk_cnt_r;
            default:     rresp_nxt = RESP_SLVERR;
         endcase
      end
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r      <= CFG_RESET;
         aw_have_r  <= 1'b0;
         w_have_r   <= 1'b0;
         awaddr_r   <= '0;
         wdata_r    <= 32'h0000_0000;
         wstrb_r    <= 4'h0;
         awready_r  <= 1'b0;
         wready_r   <= 1'b0;
         bvalid_r   <= 1'b0;
         bresp_r    <= RESP_OKAY;
         arready_r  <= 1'b0;
         rvalid_r   <= 1'b0;
         rdata_r    <= 32'h0000_0000;
         rresp_r    <= RESP_OKAY;
         fault_st_r <= 1'b0;
         blk_cnt_r  <= '0;
      end else begin
         cfg_r      <= cfg_nxt;
         aw_have_r  <= aw_have_nxt;
         w_have_r   <= w_have_nxt;
         awaddr_r   <= awaddr_nxt;
         wdata_r    <= wdata_nxt;
         wstrb_r    <= wstrb_nxt;
         awready_r  <= awready_nxt;
         wready_r   <= wready_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         arready_r  <= arready_nxt;
         rvalid_r   <= rvalid_nxt;
         rdata_r    <= rdata_nxt;
         rresp_r    <= rresp_nxt;
         fault_st_r <= fault_st_nxt;
         blk_cnt_r  <= blk_cnt_nxt;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign cpu_busy      = busy_r;
   assign cpu_ready     = rdy_r;
   assign cpu_fault     = flt_r;
   assign prog_cs       = pcs_r;
   assign data_cs       = dcs_r;
   assign addon_cs      = acs_r;
   assign dev_addr      = daddr_r;
   assign dev_oe        = oe_r;
   assign dev_we        = we_r;
endmodule : msd_decoder

// >>> common/msd_pkg.sv
// constants and types shared by the memory site decoder
package msd_pkg;
   // ***********************************************************
   // register map (byte addresses)
   // ***********************************************************
   localparam int          REG_AW        = 12;
   localparam logic [11:0] REG_CFG       = 12'h000;
   localparam logic [11:0] REG_STATUS    = 12'h004;
   localparam logic [11:0] REG_BLOCKED   = 12'h008;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // ***********************************************************
   // configuration and status fields
   // ***********************************************************
   localparam int          CFG_W         = 10;
   localparam logic [9:0]  CFG_RESET     = 10'h000;
   localparam int          CFG_PSZ_LSB   = 0;
   localparam int          CFG_DSZ_LSB   = 3;
   localparam int          CFG_RELOC     = 5;
   localparam int          CFG_EE8K      = 6;
   localparam int          CFG_ADDON     = 7;
   localparam int          CFG_WS_LSB    = 8;
   localparam int          ST_BUSY       = 0;
   localparam int          ST_PROT       = 1;
   localparam int          ST_GRP_LSB    = 2;
   localparam int          ST_FAULT      = 4;
   localparam int          CNT_W         = 16;
   // ***********************************************************
   // device size codes and decoded region widths
   // ***********************************************************
   localparam logic [2:0]  PSZ_8K        = 3'h0;
   localparam logic [2:0]  PSZ_16K       = 3'h1;
   localparam logic [2:0]  PSZ_32K       = 3'h2;
   localparam logic [2:0]  PSZ_64K       = 3'h3;
   localparam logic [2:0]  PSZ_EE2K      = 3'h4;
   localparam logic [2:0]  PSZ_EE8K      = 3'h5;
   localparam logic [1:0]  DSZ_2K        = 2'h0;
   localparam logic [1:0]  DSZ_8K        = 2'h1;
   localparam logic [1:0]  DSZ_32K       = 2'h2;
   localparam logic [4:0]  BITS_8KB      = 5'h0D;
   localparam logic [4:0]  BITS_32KB     = 5'h0F;
   localparam logic [4:0]  BITS_64KB     = 5'h10;
   localparam logic [4:0]  BITS_128KB    = 5'h11;
   localparam logic [4:0]  BITS_256KB    = 5'h12;
   localparam logic [4:0]  BITS_ADDON_MX = 5'h10;
   localparam logic [4:0]  SITE_SHIFT    = 5'h02;
   localparam int          EE2K_OFS_W    = 11;
   // ***********************************************************
   // address space, bus widths, site group codes and cycle states
   // ***********************************************************
   localparam int          CPU_AW        = 20;
   localparam int          DEV_AW        = 18;
   localparam logic [20:0] SPACE_TOP     = 21'h100000;
   localparam logic [20:0] SPACE_BOTTOM  = 21'h000000;
   localparam logic [1:0]  GRP_NONE      = 2'h0;
   localparam logic [1:0]  GRP_PROG      = 2'h1;
   localparam logic [1:0]  GRP_DATA      = 2'h2;
   localparam logic [1:0]  GRP_ADDON     = 2'h3;
   typedef enum logic {CYC_IDLE, CYC_ACCESS} msd_cyc_e;
endpackage : msd_pkg

// >>> src/msd_range.sv
// one site group window: hit test, site index and in-device offset
`timescale 1ns/1ps
module msd_range
   import msd_pkg::*;
(
   // window
   input  wire logic                  en,
   input  wire logic [20:0]           base,
   input  wire logic [4:0]            bits,
   // address
   input  wire logic [CPU_AW-1:0]     addr,
   // result
   output logic                       hit,
   output logic [1:0]                 site,
   output logic [DEV_AW-1:0]          offset
);
   logic [20:0] diff;
   logic [20:0] size;
   logic [20:0] dev_mask;
   logic [20:0] site_bits;

   always_comb begin
      diff      = {1'b0, addr} - base;
      size      = SPACE_TOP >> (BITS_256KB + SITE_SHIFT - bits);
      dev_mask  = (size >> SITE_SHIFT) - 21'h000001;
      site_bits = diff >> (bits - SITE_SHIFT);
      hit       = en && ({1'b0, addr} >= base) && (diff < size);
      site      = site_bits[1:0];
      offset    = diff[DEV_AW-1:0] & dev_mask[DEV_AW-1:0];
   end
endmodule : msd_range

// >>> src/msd_wait.sv
// wait state counter for one memory access
`timescale 1ns/1ps
module msd_wait
   import msd_pkg::*;
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // control
   input  wire logic                  load,
   input  wire logic                  abort,
   input  wire logic [1:0]            waits,
   // status
   output logic                       done
);
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic       act_r;
   logic       act_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      act_nxt = act_r;
      if (load) begin
         cnt_nxt = waits;
         act_nxt = 1'b1;
      end else if (abort || (act_r && cnt_r == 2'h0)) begin
         act_nxt = 1'b0;
      end else if (act_r) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 2'h0;
         act_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         act_r <= act_nxt;
      end
   end

   assign done = act_r && (cnt_r == 2'h0);
endmodule : msd_wait

// >>> verif/msd_decoder_props.sv
// cpu cycle assertions for the memory site decoder
`timescale 1ns/1ps
module msd_decoder_props (
   // clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // processor bus
   input wire logic       cpu_req,
   input wire logic       cpu_busy,
   input wire logic       cpu_ready,
   input wire logic       cpu_fault,
   input wire logic       aux_mem_protect,
   // memory sites
   input wire logic [3:0] prog_cs,
   input wire logic [3:0] data_cs,
   input wire logic [3:0] addon_cs,
   input wire logic       dev_oe,
   input wire logic       dev_we
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire any_cs = |{prog_cs, data_cs, addon_cs};
   wire take   = cpu_req && !cpu_busy;
   property p_one; $onehot0({prog_cs, data_cs, addon_cs}); endproperty
   a_one: assert property (p_one) else $error("two sites selected");
   property p_take; take |=> cpu_fault != cpu_busy; endproperty
   a_take: assert property (p_take) else $error("request ignored");
   property p_done; take |-> ##[1:5] (cpu_ready || cpu_fault); endproperty
   a_done: assert property (p_done) else $error("access never ended");
   property p_len; cpu_busy [*4] |=> !cpu_busy; endproperty
   a_len: assert property (p_len) else $error("too many waits");
   property p_prot; aux_mem_protect && $past(aux_mem_protect) |-> !(|{data_cs, addon_cs}); endproperty
   a_prot: assert property (p_prot) else $error("ram selected");
   property p_rdy; cpu_ready |-> $past(cpu_busy) && !cpu_busy; endproperty
   a_rdy: assert property (p_rdy) else $error("stray ready");
   property p_strobe; any_cs |-> cpu_busy && (dev_oe != dev_we); endproperty
   a_strobe: assert property (p_strobe) else $error("bad strobe");
   property p_idle; !cpu_busy |-> !any_cs && !dev_oe && !dev_we; endproperty
   a_idle: assert property (p_idle) else $error("idle select");
   c_ready: cover property (cpu_ready);
   c_fault: cover property (cpu_fault);
   c_addon: cover property (|addon_cs);
endmodule : msd_decoder_props

bind msd_decoder msd_decoder_props u_props (.aclk, .aresetn, .cpu_req, .cpu_busy, .cpu_ready, .cpu_fault,
   .aux_mem_protect, .prog_cs, .data_cs, .addon_cs, .dev_oe, .dev_we);

// >>> verif/msd_mem_model.sv
// byte-wide memory sites: record which site and offset each access hit
`timescale 1ns/1ps
module msd_mem_model
   import msd_pkg::*;
(
   // clock
   input  wire logic                       aclk,
   // memory sites
   input  wire logic [3:0]                 prog_cs,
   input  wire logic [3:0]                 data_cs,
   input  wire logic [3:0]                 addon_cs,
   input  wire logic [msd_pkg::DEV_AW-1:0] dev_addr,
   // capture
   output logic [23:0]                     seen
);
   // record group, site selects and device address while a site is selected
   always @(posedge aclk) begin
      if (|{prog_cs, data_cs, addon_cs})
         seen <= {|prog_cs ? GRP_PROG : (|data_cs ? GRP_DATA : GRP_ADDON), prog_cs | data_cs | addon_cs, dev_addr};
   end
endmodule : msd_mem_model

// >>> verif/msd_decoder_tb.sv
// self-checking bench for the memory site decoder
`timescale 1ns/1ps
module msd_decoder_tb;
   import msd_pkg::*;
   localparam logic [31:0] FLT = 32'h0100_0000;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_req, cpu_wr, cpu_busy, cpu_ready;
   logic cpu_fault, aux_mem_protect, dev_oe, dev_we;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, exp_v;
   logic [3:0]  s_axi_wstrb, prog_cs, data_cs, addon_cs;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [19:0] cpu_addr;
   logic [17:0] dev_addr;
   logic [23:0] seen;
   logic [9:0]  cfg_v;
   logic [31:0] exp_q[$];
   logic [19:0] pts[8] = '{20'hFFFFF, 20'hF8000, 20'hF7FFF, 20'hF8800, 20'hEFFFF, 20'hE0000, 20'hC0000, 20'hBFFFF};
   logic [19:0] dpts[9] = '{20'h0, 20'h1FFF, 20'h2000, 20'h4000, 20'hFFFF, 20'h10000, 20'h2FFFF, 20'hA0000, 20'hBFFFF};
   integer seed = 32'h7346ECC1;
   int mismatches, check_count, i;

   msd_decoder dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req, .cpu_wr, .cpu_addr,
      .cpu_busy, .cpu_ready, .cpu_fault, .aux_mem_protect, .prog_cs, .data_cs, .addon_cs, .dev_addr, .dev_oe, .dev_we);
   msd_mem_model u_mem (.aclk, .prog_cs, .data_cs, .addon_cs, .dev_addr, .seen);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask : check

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   task automatic wait_on(input int k);
      for (int n = 0; n < 99; n++) begin
         @(negedge aclk);
         if ((k == 2 ? s_axi_rvalid : k ? s_axi_bvalid : cpu_ready | cpu_fault) === 1'b1) return;
      end
      mismatches++;
      print_verdict;
   endtask : wait_on

   task automatic axi_wr(input logic [11:0] a, input logic [9:0] d, input logic [1:0] rsp);
      logic ta, tw;
      {ta, tw} = 2'b00;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {22'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      for (int n = 0; n < 9 && !(ta && tw); n++) begin
         @(negedge aclk);
         ta = ta | s_axi_awready;
         tw = tw | s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      wait_on(1);
      check({30'h0, s_axi_bresp}, {30'h0, rsp});
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] want);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      for (int n = 0; n < 9; n++) begin
         @(negedge aclk);
         if (s_axi_arready === 1'b1) break;
      end
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      wait_on(2);
      check({s_axi_rresp, s_axi_rdata[29:0]}, want);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic set_cfg(input logic [9:0] v);
      cfg_v = v;
      axi_wr(REG_CFG, v, RESP_OKAY);
   endtask : set_cfg

   function automatic logic [31:0] hit(input logic [1:0] g, input logic [20:0] o, input int b, input int m);
      logic [20:0] k;
      k = o & ((21'h1 << m) - 21'h1);
      return {7'h0, 1'b0, g, 4'h1 << o[b +: 2], k[17:0]};
   endfunction : hit

   function automatic logic [31:0] expect_of(input logic [19:0] a);
      int pb, db, ab;
      logic [20:0] x, pbase, dbase, abase;
      x = {1'b0, a};
      pb = (cfg_v[2:0] == PSZ_EE2K && !cfg_v[CFG_EE8K]) ? 11 : (cfg_v[2:0] < 3'h4 ? 13 + cfg_v[2:0] : 13);
      db = cfg_v[4:3] == DSZ_8K ? 13 : (cfg_v[4:3] == DSZ_32K ? 15 : 11);
      ab = db > 14 ? 14 : db;
      pbase = SPACE_TOP - (21'h4 << pb);
      dbase = cfg_v[CFG_RELOC] ? pbase - (21'h4 << db) : SPACE_BOTTOM;
      abase = dbase + (21'h4 << db);
      if (x >= pbase) return hit(GRP_PROG, x - pbase, pb, cfg_v[2:0] == PSZ_EE2K ? 11 : pb);
      if (x >= dbase && x < abase) return aux_mem_protect ? FLT : hit(GRP_DATA, x - dbase, db, db);
      if (cfg_v[CFG_ADDON] && x >= abase && x < abase + (21'h4 << ab))
         return aux_mem_protect ? FLT : hit(GRP_ADDON, x - abase, ab, ab);
      return FLT;
   endfunction : expect_of

   task automatic cpu_acc(input logic [19:0] a);
      @(posedge aclk);
      exp_q.push_back(expect_of(a));
      cpu_req <= 1'b1;
      cpu_addr <= a;
      cpu_wr <= a[0];
      @(posedge aclk);
      cpu_req <= 1'b0;
      wait_on(0);
   endtask : cpu_acc

   always @(negedge aclk) begin
      if ((cpu_ready | cpu_fault) === 1'b1 && exp_q.size() > 0) begin
         exp_v = exp_q.pop_front();
         check({7'h0, cpu_fault, cpu_fault ? 24'h0 : seen}, exp_v);
      end
   end

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      {aresetn, cpu_req, cpu_wr, aux_mem_protect, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, cpu_addr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      cfg_v = CFG_RESET;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      cpu_acc(20'hFFFFF);
      cpu_acc(20'h01FFF);
      cpu_acc(20'h02000);
      axi_wr(12'hFFC, 10'h0, RESP_SLVERR);
      for (i = 0; i < 7; i++) begin
         set_cfg(i == 6 ? 10'h244 : {i[1:0], 5'h0, i[2:0]});
         foreach (pts[j]) cpu_acc(pts[j]);
         cpu_acc(20'hFFFFF - 20'($random(seed) & 32'h7FF));
      end
      for (i = 0; i < 6; i++) begin
         set_cfg({2'h0, 2'b10, i[0], i[2:1], 3'h3});
         foreach (dpts[j]) cpu_acc(dpts[j]);
      end
      @(posedge aclk);
      exp_q.push_back(FLT);
      {cpu_req, cpu_addr, cpu_wr} <= {1'b1, 20'hA0000, 1'b0};
      @(posedge aclk);
      {cpu_req, aux_mem_protect} <= 2'b01;
      wait_on(0);
      foreach (dpts[j]) cpu_acc(dpts[j]);
      cpu_acc(20'hC0000);
      axi_rd(REG_STATUS, 32'h0000_0016);
      axi_rd(REG_BLOCKED, 32'h0000_0003);
      axi_rd(REG_CFG, {22'h0, cfg_v});
      axi_rd(12'hFFC, 32'h8000_0000);
      print_verdict;
   end
endmodule : msd_decoder_tb
